/* File: logic/arac_pkg.sv */
// Constants shared by the drive-bus register access control block.
//
// Behaviour
// R1: The flush bit clears itself one clock after firmware sets it.
// R2: While flush is set, the sector FIFO pointers and data buffers are cleared.
// R3: Firmware flushes the sector FIFO after any abnormally ended FIFO transfer.
// R4: Setting the read bit starts one drive register read; it stays set until done.
// R5: A finished read loads the holding register and clears both start bits.
// R6: With read and write set together, only the read is performed.
// R7: Setting the write bit drives the holding value in one write; it self-clears.
// R8: The four-bit select field in bits 7 to 4 addresses every transfer.
// R9: Select bit 3 low addresses the command block, lower bits choose the register.
// R10: Select bit 3 high addresses the control block, lower bits choose the register.
// R11: The data register moves 16 bits; every other drive register moves 8 bits.
// R12: Reserved drive register addresses are executed like any other access.
// R13: The holding register has low and high bytes, firmware read/write, reset zero.
// R14: Bit 0 reads the sector counter's top bit and ignores writes.
package arac_pkg;

    // ----------------------------------------------------------------
    // Register addresses on the microcontroller data bus
    // ----------------------------------------------------------------
    localparam logic [15:0] ARAC_HOLD_LO_ADDR = 16'hF0D2;
    localparam logic [15:0] ARAC_HOLD_HI_ADDR = 16'hF0D3;
    localparam logic [15:0] ARAC_CTRL_ADDR = 16'hF0D4;

    // ----------------------------------------------------------------
    // Control register field positions
    // ----------------------------------------------------------------
    localparam int ARAC_SECT_MSB_BIT = 0;
    localparam int ARAC_FLUSH_BIT = 1;
    localparam int ARAC_RD_BIT = 2;
    localparam int ARAC_WR_BIT = 3;
    localparam int ARAC_SEL_LSB = 4;
    localparam int ARAC_SEL_MSB = 7;
    localparam int ARAC_SEL_BLOCK_BIT = 3;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] ARAC_BYTE_RESET = 8'h00;
    localparam logic [3:0] ARAC_SEL_RESET = 4'h0;
    localparam logic [3:0] ARAC_DATA_REG_SEL = 4'h0;
    localparam logic [7:0] ARAC_UNMAPPED_READ = 8'h00;
    localparam logic [7:0] ARAC_CNT_ZERO = 8'h00;
    localparam logic [7:0] ARAC_CNT_ONE = 8'h01;

    // Default strobe timing, in core clock cycles.
    localparam int ARAC_SETUP_CYCLES = 3;
    localparam int ARAC_PULSE_CYCLES = 8;
    localparam int ARAC_RECOVERY_CYCLES = 4;

    typedef enum logic [1:0] {
        ARAC_IDLE,
        ARAC_SETUP,
        ARAC_STROBE,
        ARAC_RECOVER
    } arac_state_t;

endpackage

/* File: logic/arac_core.sv */
// Drive-bus register access control: single register transfers and FIFO flush.
`timescale 1ns/1ps
`default_nettype none
module arac_core
#(
    parameter logic [7:0] SETUP_CYCLES = 8'(arac_pkg::ARAC_SETUP_CYCLES),
    parameter logic [7:0] PULSE_CYCLES = 8'(arac_pkg::ARAC_PULSE_CYCLES),
    parameter logic [7:0] RECOVERY_CYCLES = 8'(arac_pkg::ARAC_RECOVERY_CYCLES)
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Microcontroller data bus
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    input wire logic xrd,
    output logic [7:0] xrdata,
    // Sector FIFO and counter
    output logic sector_fifo_flush,
    input wire logic sector_count_msb,
    output logic transfer_busy,
    // Drive bus
    output logic drv_cs0_n,
    output logic drv_cs1_n,
    output logic [2:0] drv_addr,
    output logic drv_rd_n,
    output logic drv_wr_n,
    output logic [15:0] drv_data_out,
    output logic drv_data_oe_lo,
    output logic drv_data_oe_hi,
    input wire logic [15:0] drv_data_in
);
    import arac_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] hold_lo;
    logic [7:0] hold_hi;
    logic [3:0] drive_register_select;
    logic bus_register_read_go;
    logic bus_register_write_go;
    logic flush;
    arac_state_t state;
    arac_state_t next_state;
    logic [7:0] cnt;
    logic op_read;
    logic op_wide;
    logic [3:0] op_sel;
    logic [15:0] din_meta;
    logic [15:0] din_sync;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire hit_lo = xaddr == ARAC_HOLD_LO_ADDR;
    wire hit_hi = xaddr == ARAC_HOLD_HI_ADDR;
    wire hit_ctrl = xaddr == ARAC_CTRL_ADDR;
    wire wr_lo = xwr && hit_lo;
    wire wr_hi = xwr && hit_hi;
    wire wr_ctrl = xwr && hit_ctrl;
    wire set_rd = wr_ctrl && xwdata[ARAC_RD_BIT];
    wire set_wr = wr_ctrl && xwdata[ARAC_WR_BIT];
    wire idle = state == ARAC_IDLE;
    wire start = idle && (bus_register_read_go || bus_register_write_go);
    wire cnt_done = cnt == ARAC_CNT_ONE;
    wire done = state == ARAC_RECOVER && cnt_done;
    wire read_capture = state == ARAC_STROBE && cnt_done && op_read;
    wire start_wide = drive_register_select == ARAC_DATA_REG_SEL; // R11
    wire [7:0] ctrl_view = {drive_register_select, bus_register_write_go,
                            bus_register_read_go, flush, sector_count_msb}; // R14
    wire [7:0] next_rdata = hit_lo ? hold_lo :
                            hit_hi ? hold_hi :
                            hit_ctrl ? ctrl_view : ARAC_UNMAPPED_READ;
    // Read data of an 8-bit register lands in the low byte, high byte cleared.
    wire [7:0] cap_hi = op_wide ? din_sync[15:8] : ARAC_BYTE_RESET; // R11

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ARAC_IDLE:
            begin
                if (start)
                    next_state = ARAC_SETUP; // R4 R7 R12
            end
            ARAC_SETUP:
            begin
                if (cnt_done)
                    next_state = ARAC_STROBE;
            end
            ARAC_STROBE:
            begin
                if (cnt_done)
                    next_state = ARAC_RECOVER;
            end
            ARAC_RECOVER:
            begin
                if (cnt_done)
                    next_state = ARAC_IDLE;
            end
        endcase
    end

    wire [7:0] next_cnt = start ? SETUP_CYCLES :
                          (state == ARAC_SETUP && cnt_done) ? PULSE_CYCLES :
                          (state == ARAC_STROBE && cnt_done) ? RECOVERY_CYCLES :
                          (cnt != ARAC_CNT_ZERO) ? cnt - ARAC_CNT_ONE : ARAC_CNT_ZERO;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ARAC_IDLE;
            cnt <= ARAC_CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Transfer attributes are frozen at start so firmware edits cannot disturb it.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_read <= 1'b0;
            op_wide <= 1'b0;
            op_sel <= ARAC_SEL_RESET;
        end
        else if (start)
        begin
            op_read <= bus_register_read_go; // R6
            op_wide <= start_wide; // R11
            op_sel <= drive_register_select; // R8
        end
    end

    // ----------------------------------------------------------------
    // Drive data input synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
        end
        else
        begin
            din_meta <= drv_data_in;
            din_sync <= din_meta;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            drive_register_select <= ARAC_SEL_RESET;
            bus_register_read_go <= 1'b0;
            bus_register_write_go <= 1'b0;
            flush <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                drive_register_select <= xwdata[ARAC_SEL_MSB:ARAC_SEL_LSB]; // R8
            flush <= wr_ctrl && xwdata[ARAC_FLUSH_BIT]; // R1
            // A firmware start in the completion cycle wins over the self-clear.
            if (set_rd)
                bus_register_read_go <= 1'b1; // R4
            else if (done)
                bus_register_read_go <= 1'b0; // R5
            if (set_wr)
                bus_register_write_go <= 1'b1; // R7
            else if (done)
                bus_register_write_go <= 1'b0; // R5 R7
        end
    end

    // ----------------------------------------------------------------
    // Holding register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_lo <= ARAC_BYTE_RESET;
            hold_hi <= ARAC_BYTE_RESET;
        end
        else if (read_capture)
        begin
            hold_lo <= din_sync[7:0]; // R5
            hold_hi <= cap_hi; // R5
        end
        else
        begin
            if (wr_lo)
                hold_lo <= xwdata; // R13
            if (wr_hi)
                hold_hi <= xwdata; // R13
        end
    end

    // ----------------------------------------------------------------
    // Read data and drive bus outputs
    // ----------------------------------------------------------------
    wire active = !idle;
    wire strobe = state == ARAC_STROBE;
    wire drive_out = active && !op_read;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xrdata <= ARAC_UNMAPPED_READ;
            drv_cs0_n <= 1'b1;
            drv_cs1_n <= 1'b1;
            drv_addr <= 3'h0;
            drv_rd_n <= 1'b1;
            drv_wr_n <= 1'b1;
            drv_data_out <= 16'h0000;
            drv_data_oe_lo <= 1'b0;
            drv_data_oe_hi <= 1'b0;
        end
        else
        begin
            if (xrd)
                xrdata <= next_rdata;
            drv_cs0_n <= !(active && !op_sel[ARAC_SEL_BLOCK_BIT]); // R9
            drv_cs1_n <= !(active && op_sel[ARAC_SEL_BLOCK_BIT]); // R10
            drv_addr <= op_sel[2:0]; // R9 R10
            drv_rd_n <= !(strobe && op_read);
            drv_wr_n <= !(strobe && !op_read);
            drv_data_out <= {hold_hi, hold_lo}; // R7
            drv_data_oe_lo <= drive_out;
            drv_data_oe_hi <= drive_out && op_wide; // R11
        end
    end

    assign sector_fifo_flush = flush; // R2
    assign transfer_busy = active;

endmodule
`default_nettype wire

/* File: tb/arac_props.sv */
// Concurrent checks on the drive-bus register access control ports.
`timescale 1ns/1ps
`default_nettype none
module arac_props
#(
    parameter logic [7:0] SETUP_CYCLES = 8'h03,
    parameter logic [7:0] PULSE_CYCLES = 8'h08,
    parameter logic [7:0] RECOVERY_CYCLES = 8'h04
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Microcontroller data bus
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    // Status
    input wire logic sector_fifo_flush,
    input wire logic transfer_busy,
    // Drive bus
    input wire logic drv_cs0_n,
    input wire logic drv_cs1_n,
    input wire logic [2:0] drv_addr,
    input wire logic drv_rd_n,
    input wire logic drv_wr_n,
    input wire logic drv_data_oe_lo,
    input wire logic drv_data_oe_hi
);
    import arac_pkg::*;
    localparam int BUSY_MIN = SETUP_CYCLES + PULSE_CYCLES + RECOVERY_CYCLES - 1;
    localparam int BUSY_MAX = BUSY_MIN + 3;
    logic [3:0] sel_q;
    logic rd_q;
    logic [7:0] busy_len;
    wire ctrl_wr = xwr && xaddr == ARAC_CTRL_ADDR;
    wire flush_req = ctrl_wr && xwdata[ARAC_FLUSH_BIT];
    wire read_req = ctrl_wr && xwdata[ARAC_RD_BIT] && !transfer_busy;
    // Mirrors the select and read request that an idle control write hands to a transfer.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_q <= ARAC_SEL_RESET;
            rd_q <= 1'b0;
        end
        else if (ctrl_wr && !transfer_busy)
        begin
            sel_q <= xwdata[ARAC_SEL_MSB:ARAC_SEL_LSB];
            rd_q <= xwdata[ARAC_RD_BIT];
        end
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            busy_len <= 8'h00;
        else
            busy_len <= transfer_busy ? busy_len + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence flush_pulse;
        sector_fifo_flush ##1 !sector_fifo_flush;
    endsequence
    sequence strobe_low;
        !drv_rd_n [*8];
    endsequence
    flush_once_a: assert property (flush_req |=> flush_pulse)
        else $error("flush pulse length wrong");
    flush_cause_a: assert property ($rose(sector_fifo_flush) |-> $past(flush_req))
        else $error("flush without request");
    read_start_a: assert property (read_req |-> ##2 transfer_busy)
        else $error("read did not start");
    busy_len_a: assert property ($fell(transfer_busy) |->
        busy_len >= BUSY_MIN && busy_len <= BUSY_MAX)
        else $error("transfer length wrong");
    rd_width_a: assert property ($fell(drv_rd_n) |-> strobe_low ##1 drv_rd_n)
        else $error("read strobe width wrong");
    cmd_select_a: assert property ($fell(drv_cs0_n) |->
        !sel_q[ARAC_SEL_BLOCK_BIT] && drv_cs1_n && drv_addr == sel_q[2:0])
        else $error("command block select wrong");
    ctl_select_a: assert property ($fell(drv_cs1_n) |->
        sel_q[ARAC_SEL_BLOCK_BIT] && drv_cs0_n && drv_addr == sel_q[2:0])
        else $error("control block select wrong");
    write_width_a: assert property (!drv_wr_n |->
        drv_data_oe_lo && drv_data_oe_hi == (sel_q == ARAC_DATA_REG_SEL))
        else $error("write width wrong");
    read_only_a: assert property (!drv_wr_n |-> !rd_q)
        else $error("write ran beside a read");
endmodule
`default_nettype wire

/* File: tb/arac_drive_model.sv */
// Behavioural drive answering register transfers on the far side.
`timescale 1ns/1ps
`default_nettype none
module arac_drive_model (
    // Clock
    input wire logic mclk,
    // Drive bus
    input wire logic drv_cs1_n,
    input wire logic [2:0] drv_addr,
    input wire logic drv_rd_n,
    input wire logic drv_wr_n,
    input wire logic [15:0] drv_data_out,
    input wire logic drv_data_oe_lo,
    input wire logic drv_data_oe_hi,
    output logic [15:0] drv_data_in,
    // Observation
    output logic [15:0] last_write,
    output int write_count
);
    logic wr_d = 1'b1;
    wire [3:0] key = {!drv_cs1_n, drv_addr};
    initial drv_data_in = 16'h0000;
    initial last_write = 16'h0000;
    initial write_count = 0;
    // Released data lines toggle so a late capture never sees a stale reply.
    always @(posedge mclk)
    begin
        drv_data_in <= drv_rd_n ? ~drv_data_in : {4'hA, key, 4'h5, key};
        wr_d <= drv_wr_n;
        if (!drv_wr_n)
            last_write <= {drv_data_oe_hi ? drv_data_out[15:8] : 8'h00,
                drv_data_oe_lo ? drv_data_out[7:0] : 8'h00};
        if (drv_wr_n && !wr_d)
            write_count <= write_count + 1;
    end
endmodule
`default_nettype wire

/* File: tb/ata_register_access_control_bench.sv */
// Self-checking bench for the drive-bus register access control block.
`timescale 1ns/1ps
`default_nettype none
module ata_register_access_control_bench;
    import arac_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, xwr = 1'b0, xrd = 1'b0, sector_count_msb = 1'b1;
    logic [15:0] xaddr = 16'h0000;
    logic [7:0] xwdata = 8'h00;
    logic [15:0] drv_data_in, drv_data_out, last_write, x16;
    logic [7:0] xrdata, qv, lo, hi;
    logic [2:0] drv_addr;
    logic [3:0] sv;
    logic sector_fifo_flush, transfer_busy, drv_cs0_n, drv_cs1_n, drv_rd_n, drv_wr_n;
    logic drv_data_oe_lo, drv_data_oe_hi, rd_flag = 1'b0;
    logic [31:0] seed = 32'h00010DE1;
    logic [7:0] q[$];
    int bad_count = 0, tests_run = 0, write_count, wc;
    arac_core dut_u (.mclk, .arst_n, .xaddr, .xwdata, .xwr, .xrd, .xrdata, .sector_fifo_flush,
        .sector_count_msb, .transfer_busy, .drv_cs0_n, .drv_cs1_n, .drv_addr, .drv_rd_n,
        .drv_wr_n, .drv_data_out, .drv_data_oe_lo, .drv_data_oe_hi, .drv_data_in);
    arac_drive_model model_u (.mclk, .drv_cs1_n, .drv_addr, .drv_rd_n, .drv_wr_n,
        .drv_data_out, .drv_data_oe_lo, .drv_data_oe_hi, .drv_data_in, .last_write,
        .write_count);
    initial forever #12.5 mclk = ~mclk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic report_and_stop();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected read at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected drive value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        xaddr = a;
        xwdata = d;
        xwr = 1'b1;
        @(posedge mclk) #2;
        xwr = 1'b0;
        @(posedge mclk) #2;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        q.push_back(e);
        xaddr = a;
        xrd = 1'b1;
        @(posedge mclk) #2;
        xrd = 1'b0;
        @(posedge mclk) #2;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge mclk);
        while (transfer_busy !== 1'b0 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        repeat (3) @(posedge mclk);
        #2;
        if (n >= 100)
        begin
            chk8(8'h01, 8'h00);
            report_and_stop();
        end
    endtask
    // Read data is settled one cycle after the strobe edge, so it is taken at the falling edge.
    always @(posedge mclk) rd_flag <= xrd;
    always @(negedge mclk)
    begin
        if (rd_flag)
        begin
            qv = q.pop_front();
            chk8(xrdata, qv);
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        #2 arst_n = 1'b1;
        @(posedge mclk) #2;
        rd(ARAC_HOLD_LO_ADDR, ARAC_BYTE_RESET);
        rd(ARAC_HOLD_HI_ADDR, ARAC_BYTE_RESET);
        rd(ARAC_CTRL_ADDR, ARAC_CNT_ONE);
        sector_count_msb = 1'b0;
        wr(ARAC_CTRL_ADDR, 8'h01);
        rd(ARAC_CTRL_ADDR, ARAC_CNT_ZERO);
        rd(16'hF0D5, ARAC_UNMAPPED_READ);
        xaddr = ARAC_CTRL_ADDR;
        xwdata = 8'h02;
        xwr = 1'b1;
        @(posedge mclk) #2;
        xwr = 1'b0;
        rd(ARAC_CTRL_ADDR, 8'h02);
        rd(ARAC_CTRL_ADDR, 8'h00);
        $display("test registers and flush done");
        for (int m = 0; m < 3; m++)
        begin
            for (int s = 0; s < 16; s++)
            begin
                sv = 4'(s);
                lo = rnd();
                hi = rnd();
                wr(ARAC_HOLD_LO_ADDR, lo);
                wr(ARAC_HOLD_HI_ADDR, hi);
                wc = write_count;
                wr(ARAC_CTRL_ADDR, {sv, m > 0, m != 1, 2'b00});
                wait_idle();
                rd(ARAC_CTRL_ADDR, {sv, 4'h0});
                x16 = {4'hA, sv, 4'h5, sv};
                if (m == 1)
                begin
                    chk16(last_write, sv == ARAC_DATA_REG_SEL ? {hi, lo} : {8'h00, lo});
                    chk16(16'(write_count), 16'(wc + 1));
                    rd(ARAC_HOLD_LO_ADDR, lo);
                end
                else
                begin
                    chk16(16'(write_count), 16'(wc));
                    rd(ARAC_HOLD_LO_ADDR, x16[7:0]);
                    rd(ARAC_HOLD_HI_ADDR, sv == ARAC_DATA_REG_SEL ? x16[15:8] : 8'h00);
                end
            end
            $display("test transfer mode %0d done", m);
        end
        report_and_stop();
    end
endmodule
bind arac_core arac_props #(.SETUP_CYCLES(SETUP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
    .RECOVERY_CYCLES(RECOVERY_CYCLES)) props_u (.mclk, .arst_n, .xaddr, .xwdata, .xwr,
    .sector_fifo_flush, .transfer_busy, .drv_cs0_n, .drv_cs1_n, .drv_addr, .drv_rd_n,
    .drv_wr_n, .drv_data_oe_lo, .drv_data_oe_hi);
`default_nettype wire
